// File: hdl/ccwvs_setup.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module ccwvs_setup #(
  parameter int          NUM_QUEUES    = 4,
  parameter int          FEAT_WORDS    = 2,
  parameter int          CFG_WORDS     = 4,
  parameter logic [15:0] QUEUE_MAX_NUM = 16'h0100
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata
);
  import ccwvs_pkg::*;

  typedef struct packed {
    logic                             pready;
    logic                             pslverr;
    logic [31:0]                      prdata;
    logic [7:0]                       last_cmd;
    logic                             done;
    logic                             reject;
    logic                             rev_set;
    logic                             rev1;
    logic                             ind_classic;
    logic                             ind_adapter;
    logic                             conf_ind_set;
    logic                             transitional;
    logic                             sch_en;
    logic [5:0]                       len;
    logic [7:0]                       dev_status;
    logic [7:0]                       stat_ok;
    logic [15:0]                      info_sel;
    logic [7:0]                       feat_sel;
    logic [7:0][31:0]                 payload;
    logic [CFG_WORDS-1:0][31:0]       cfg;
    logic [FEAT_WORDS-1:0][31:0]      dev_feat;
    logic [FEAT_WORDS-1:0][31:0]      drv_feat;
    logic [NUM_QUEUES-1:0][63:0]      q_desc;
    logic [NUM_QUEUES-1:0][63:0]      q_avail;
    logic [NUM_QUEUES-1:0][63:0]      q_used;
    logic [NUM_QUEUES-1:0][15:0]      q_num;
    logic [NUM_QUEUES-1:0][31:0]      q_align;
    logic [63:0]                      ind_addr;
    logic [63:0]                      conf_ind_addr;
    logic [63:0]                      sum_addr;
    logic [63:0]                      area_addr;
    logic [63:0]                      bit_nr;
    logic [7:0]                       isc;
  } ccwvs_state_type;

  ccwvs_state_type s_reg;
  ccwvs_state_type s_next;

  logic       dec_known;
  logic       dec_transport;
  logic [5:0] dec_len;
  logic       eff_rev1;

  // Little-endian feature word sits byte-reversed in the big-endian payload
  function automatic logic [31:0] swap32(input logic [31:0] w);
    swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Queue index check shared by query and placement
  function automatic logic q_ok(input logic [15:0] idx);
    q_ok = (32'(idx) < NUM_QUEUES);
  endfunction

  // A command issued before any revision runs as revision 0 on the legacy path
  assign eff_rev1 = s_reg.rev_set ? s_reg.rev1 : 1'b0;

  ccwvs_decode #(
    .CFG_WORDS (CFG_WORDS)
  ) u_decode (
    .op        (pwdata[7:0]),
    .rev1      (eff_rev1),
    .known     (dec_known),
    .transport (dec_transport),
    .exp_len   (dec_len)
  );

  // Bus decode, register writes and command execution
  always_comb begin
    logic        acc_wr;
    logic        setup;
    logic        rej;
    logic        exec;
    logic [7:0]  op;
    logic [15:0] qi;
    logic [7:0]  fi;
    logic [3:0]  iq;
    s_next = s_reg;
    acc_wr = psel & penable & s_reg.pready & pwrite;
    setup  = psel & ~penable;
    rej    = 1'b0;
    exec   = 1'b0;
    op     = pwdata[7:0];
    qi     = 16'h0000;
    fi     = 8'h00;
    iq     = s_reg.info_sel[11:8];

    // Answer is prepared in the setup cycle so pready can come from a flop
    s_next.pready  = setup;
    s_next.pslverr = 1'b0;
    if (setup) begin
      s_next.prdata = 32'h0000_0000;
      if (paddr[7:5] == REGION_PAYLOAD) begin
        s_next.prdata = s_reg.payload[paddr[4:2]];
      end else if (paddr[7:5] == REGION_CONFIG) begin
        if (32'(paddr[4:2]) < CFG_WORDS) begin
          s_next.prdata = s_reg.cfg[paddr[4:2]];
        end else begin
          s_next.pslverr = 1'b1;
        end
      end else begin
        unique case (paddr)
          OFS_CMD:      s_next.prdata = {24'h00_0000, s_reg.last_cmd};
          OFS_RESULT:   s_next.prdata = {25'h000_0000, s_reg.conf_ind_set, s_reg.ind_adapter,
                                         s_reg.ind_classic, s_reg.rev1, s_reg.rev_set,
                                         s_reg.reject, s_reg.done};
          OFS_CTRL:     s_next.prdata = {30'h0000_0000, s_reg.sch_en, s_reg.transitional};
          OFS_LEN:      s_next.prdata = {26'h000_0000, s_reg.len};
          OFS_STATUS:   s_next.prdata = {24'h00_0000, s_reg.dev_status};
          OFS_STAT_OK:  s_next.prdata = {24'h00_0000, s_reg.stat_ok};
          OFS_INFO_SEL: s_next.prdata = {16'h0000, s_reg.info_sel};
          OFS_FEAT_SEL: s_next.prdata = {24'h00_0000, s_reg.feat_sel};
          OFS_FEAT_DEV: s_next.prdata = (32'(s_reg.feat_sel) < FEAT_WORDS) ?
                                        s_reg.dev_feat[s_reg.feat_sel] : 32'h0000_0000;
          OFS_FEAT_DRV: s_next.prdata = (32'(s_reg.feat_sel) < FEAT_WORDS) ?
                                        s_reg.drv_feat[s_reg.feat_sel] : 32'h0000_0000;
          OFS_INFO: begin
            if (32'(iq) < NUM_QUEUES) begin
              unique case (s_reg.info_sel[4:0])
                INF_DESC_LO:  s_next.prdata = s_reg.q_desc[iq][31:0];
                INF_DESC_HI:  s_next.prdata = s_reg.q_desc[iq][63:32];
                INF_AVAIL_LO: s_next.prdata = s_reg.q_avail[iq][31:0];
                INF_AVAIL_HI: s_next.prdata = s_reg.q_avail[iq][63:32];
                INF_USED_LO:  s_next.prdata = s_reg.q_used[iq][31:0];
                INF_USED_HI:  s_next.prdata = s_reg.q_used[iq][63:32];
                INF_NUM:      s_next.prdata = {16'h0000, s_reg.q_num[iq]};
                INF_ALIGN:    s_next.prdata = s_reg.q_align[iq];
                default:      s_next.prdata = 32'h0000_0000;
              endcase
            end
            unique case (s_reg.info_sel[4:0])
              INF_IND_LO:  s_next.prdata = s_reg.ind_addr[31:0];
              INF_IND_HI:  s_next.prdata = s_reg.ind_addr[63:32];
              INF_CIND_LO: s_next.prdata = s_reg.conf_ind_addr[31:0];
              INF_CIND_HI: s_next.prdata = s_reg.conf_ind_addr[63:32];
              INF_SUM_LO:  s_next.prdata = s_reg.sum_addr[31:0];
              INF_SUM_HI:  s_next.prdata = s_reg.sum_addr[63:32];
              INF_AREA_LO: s_next.prdata = s_reg.area_addr[31:0];
              INF_AREA_HI: s_next.prdata = s_reg.area_addr[63:32];
              INF_BIT_LO:  s_next.prdata = s_reg.bit_nr[31:0];
              INF_BIT_HI:  s_next.prdata = s_reg.bit_nr[63:32];
              INF_ISC:     s_next.prdata = {24'h00_0000, s_reg.isc};
              default:     ;
            endcase
          end
          default:      s_next.pslverr = 1'b1;
        endcase
      end
    end

    // Plain register writes; read-only registers ignore writes
    if (acc_wr) begin
      if (paddr[7:5] == REGION_PAYLOAD) begin
        s_next.payload[paddr[4:2]] = pwdata;
      end else if (paddr[7:5] == REGION_CONFIG) begin
        if (32'(paddr[4:2]) < CFG_WORDS) begin
          s_next.cfg[paddr[4:2]] = pwdata;
        end
      end else begin
        unique case (paddr)
          OFS_CTRL: begin
            s_next.transitional = pwdata[CTRL_TRANSITIONAL];
            s_next.sch_en       = pwdata[CTRL_SCH_ENABLE];
            if (pwdata[CTRL_SCH_ENABLE] & ~s_reg.sch_en) begin
              s_next.rev_set = 1'b0;
              s_next.rev1    = 1'b0;
            end
          end
          OFS_LEN:      s_next.len = pwdata[5:0];
          OFS_STAT_OK:  s_next.stat_ok = pwdata[7:0];
          OFS_INFO_SEL: s_next.info_sel = pwdata[15:0];
          OFS_FEAT_SEL: s_next.feat_sel = pwdata[7:0];
          OFS_FEAT_DEV: begin
            if (32'(s_reg.feat_sel) < FEAT_WORDS) begin
              s_next.dev_feat[s_reg.feat_sel] = pwdata;
            end
          end
          default: ;
        endcase
      end
    end

    // Command gate: revision handling decides whether the body runs
    if (acc_wr && paddr == OFS_CMD) begin
      s_next.last_cmd = op;
      s_next.done     = 1'b1;
      if (!dec_known) begin
        rej = 1'b1;
      end else if (!dec_transport) begin
        rej = 1'b0;
      end else if (op == OP_SET_REV) begin
        // Revision may be chosen once per enablement; legacy mode also lands here
        if (s_reg.rev_set || s_reg.len < LEN_REV || s_reg.payload[0][15:0] != 16'h0000) begin
          rej = 1'b1;
        end else if (s_reg.payload[0][31:16] == REV_ONE) begin
          s_next.rev_set = 1'b1;
          s_next.rev1    = 1'b1;
        end else if (s_reg.payload[0][31:16] == REV_LEGACY && s_reg.transitional) begin
          s_next.rev_set = 1'b1;
          s_next.rev1    = 1'b0;
        end else begin
          rej = 1'b1;
        end
      end else if (!s_reg.rev_set && !s_reg.transitional) begin
        rej = 1'b1;
      end else begin
        if (!s_reg.rev_set) begin
          s_next.rev_set = 1'b1;
          s_next.rev1    = 1'b0;
        end
        // Short payloads fail; long ones are accepted
        if (s_reg.len < dec_len) begin
          rej = 1'b1;
        end else begin
          exec = 1'b1;
        end
      end
    end

    // Command bodies; payload is a big-endian byte stream, byte 0 in bits 31:24 of word 0
    if (exec) begin
      unique case (op)
        OP_READ_VQ_CONF: begin
          qi = s_reg.payload[0][31:16];
          s_next.payload[0][15:0] = q_ok(qi) ? QUEUE_MAX_NUM : 16'h0000;
        end
        OP_SET_VQ: begin
          qi = s_reg.payload[3][31:16];
          if (!q_ok(qi) || s_reg.payload[3][15:0] > QUEUE_MAX_NUM) begin
            rej = 1'b1;
          end else begin
            // Word 2 is the reserved field on revision 1 and is read only as the alignment on revision 0
            s_next.q_desc[qi[3:0]] = {s_reg.payload[0], s_reg.payload[1]};
            s_next.q_num[qi[3:0]]  = s_reg.payload[3][15:0];
            if (eff_rev1) begin
              s_next.q_avail[qi[3:0]] = {s_reg.payload[4], s_reg.payload[5]};
              s_next.q_used[qi[3:0]]  = {s_reg.payload[6], s_reg.payload[7]};
            end else begin
              s_next.q_align[qi[3:0]] = s_reg.payload[2];
            end
          end
        end
        OP_WRITE_STATUS: begin
          // Bits outside the acceptable mask leave the status untouched
          if ((s_reg.payload[0][31:24] & ~s_reg.stat_ok) != 8'h00) begin
            rej = 1'b1;
          end else begin
            s_next.dev_status = s_reg.payload[0][31:24];
          end
        end
        OP_READ_FEAT: begin
          fi = s_reg.payload[1][31:24];
          s_next.payload[0] = (32'(fi) < FEAT_WORDS) ? swap32(s_reg.dev_feat[fi]) : 32'h0000_0000;
        end
        OP_WRITE_FEAT: begin
          fi = s_reg.payload[1][31:24];
          if (32'(fi) < FEAT_WORDS) begin
            s_next.drv_feat[fi] = swap32(s_reg.payload[0]);
          end
        end
        OP_READ_CONF: begin
          for (int i = 0; i < CFG_WORDS; i++) begin
            s_next.payload[i] = s_reg.cfg[i];
          end
        end
        OP_WRITE_CONF: begin
          for (int i = 0; i < CFG_WORDS; i++) begin
            s_next.cfg[i] = s_reg.payload[i];
          end
        end
        OP_SET_IND: begin
          if (s_reg.ind_adapter) begin
            rej = 1'b1;
          end else begin
            s_next.ind_addr    = {s_reg.payload[0], s_reg.payload[1]};
            s_next.ind_classic = 1'b1;
          end
        end
        OP_SET_CONF_IND: begin
          s_next.conf_ind_addr = {s_reg.payload[0], s_reg.payload[1]};
          s_next.conf_ind_set  = 1'b1;
        end
        OP_SET_IND_ADPT: begin
          if (s_reg.ind_classic) begin
            rej = 1'b1;
          end else begin
            // Bit number counts from the MSB of the area's first byte
            s_next.sum_addr    = {s_reg.payload[0], s_reg.payload[1]};
            s_next.area_addr   = {s_reg.payload[2], s_reg.payload[3]};
            s_next.bit_nr      = {s_reg.payload[4], s_reg.payload[5]};
            s_next.isc         = s_reg.payload[6][31:24];
            s_next.ind_adapter = 1'b1;
          end
        end
        OP_VDEV_RESET: begin
          s_next.dev_status   = 8'h00;
          s_next.ind_classic  = 1'b0;
          s_next.ind_adapter  = 1'b0;
          s_next.conf_ind_set = 1'b0;
          s_next.q_desc       = '0;
          s_next.q_avail      = '0;
          s_next.q_used       = '0;
          s_next.q_num        = '0;
          s_next.q_align      = '0;
        end
        default: ;
      endcase
    end

    if (acc_wr && paddr == OFS_CMD) begin
      s_next.reject = rej;
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg              <= '0;
      s_reg.stat_ok      <= STAT_OK_RESET;
      s_reg.transitional <= TRANSITIONAL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pready  = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign prdata  = s_reg.prdata;

endmodule

// File: hdl/ccwvs_pkg.sv
// Shared constants for the channel-command setup interpreter
package ccwvs_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_RESULT   = 8'h04;
  localparam logic [7:0] OFS_CTRL     = 8'h08;
  localparam logic [7:0] OFS_LEN      = 8'h0c;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_STAT_OK  = 8'h14;
  localparam logic [7:0] OFS_INFO_SEL = 8'h18;
  localparam logic [7:0] OFS_INFO     = 8'h1c;
  localparam logic [7:0] OFS_FEAT_SEL = 8'h20;
  localparam logic [7:0] OFS_FEAT_DEV = 8'h24;
  localparam logic [7:0] OFS_FEAT_DRV = 8'h28;
  localparam logic [2:0] REGION_PAYLOAD = 3'h2;  // 0x40..0x5c, address bits [7:5]
  localparam logic [2:0] REGION_CONFIG  = 3'h3;  // 0x60..0x7c, address bits [7:5]

  // Result register bit positions
  localparam int RES_DONE     = 0;
  localparam int RES_REJECT   = 1;
  localparam int RES_REV_SET  = 2;
  localparam int RES_REV1     = 3;
  localparam int RES_CLASSIC  = 4;
  localparam int RES_ADAPTER  = 5;
  localparam int RES_CONF_IND = 6;

  // Control register bit positions and reset values
  localparam int         CTRL_TRANSITIONAL = 0;
  localparam int         CTRL_SCH_ENABLE   = 1;
  localparam logic       TRANSITIONAL_RESET = 1'b1;
  localparam logic [7:0] STAT_OK_RESET      = 8'hff;

  // Channel command codes
  localparam logic [7:0] OP_NOOP         = 8'h03;
  localparam logic [7:0] OP_SET_VQ       = 8'h13;
  localparam logic [7:0] OP_VDEV_RESET   = 8'h33;
  localparam logic [7:0] OP_SET_IND      = 8'h43;
  localparam logic [7:0] OP_SET_CONF_IND = 8'h53;
  localparam logic [7:0] OP_SET_IND_ADPT = 8'h73;
  localparam logic [7:0] OP_READ_FEAT    = 8'h12;
  localparam logic [7:0] OP_WRITE_FEAT   = 8'h11;
  localparam logic [7:0] OP_READ_CONF    = 8'h22;
  localparam logic [7:0] OP_WRITE_CONF   = 8'h21;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h31;
  localparam logic [7:0] OP_READ_VQ_CONF = 8'h32;
  localparam logic [7:0] OP_SET_REV      = 8'h83;

  // Least payload lengths in bytes
  localparam logic [5:0] LEN_REV      = 6'h04;
  localparam logic [5:0] LEN_VQ_CONF  = 6'h04;
  localparam logic [5:0] LEN_SET_VQ   = 6'h20;
  localparam logic [5:0] LEN_SET_VQ0  = 6'h10;
  localparam logic [5:0] LEN_STATUS   = 6'h01;
  localparam logic [5:0] LEN_FEAT     = 6'h05;
  localparam logic [5:0] LEN_IND      = 6'h08;
  localparam logic [5:0] LEN_ADAPTER  = 6'h19;

  // Revision values
  localparam logic [15:0] REV_LEGACY = 16'h0000;
  localparam logic [15:0] REV_ONE    = 16'h0001;

  // Info selector fields (info_sel[4:0])
  localparam logic [4:0] INF_DESC_LO  = 5'h00;
  localparam logic [4:0] INF_DESC_HI  = 5'h01;
  localparam logic [4:0] INF_AVAIL_LO = 5'h02;
  localparam logic [4:0] INF_AVAIL_HI = 5'h03;
  localparam logic [4:0] INF_USED_LO  = 5'h04;
  localparam logic [4:0] INF_USED_HI  = 5'h05;
  localparam logic [4:0] INF_NUM      = 5'h06;
  localparam logic [4:0] INF_ALIGN    = 5'h07;
  localparam logic [4:0] INF_IND_LO   = 5'h08;
  localparam logic [4:0] INF_IND_HI   = 5'h09;
  localparam logic [4:0] INF_CIND_LO  = 5'h0a;
  localparam logic [4:0] INF_CIND_HI  = 5'h0b;
  localparam logic [4:0] INF_SUM_LO   = 5'h0c;
  localparam logic [4:0] INF_SUM_HI   = 5'h0d;
  localparam logic [4:0] INF_AREA_LO  = 5'h0e;
  localparam logic [4:0] INF_AREA_HI  = 5'h0f;
  localparam logic [4:0] INF_BIT_LO   = 5'h10;
  localparam logic [4:0] INF_BIT_HI   = 5'h11;
  localparam logic [4:0] INF_ISC      = 5'h12;

endpackage

// File: hdl/ccwvs_decode.sv
`timescale 1ns/1ps
// Classifies a channel command code and gives its least payload length
module ccwvs_decode #(
  parameter int CFG_WORDS = 4
) (
  // Command
  input  wire logic [7:0] op,
  input  wire logic       rev1,
  // Classification
  output logic            known,
  output logic            transport,
  output logic [5:0]      exp_len
);
  import ccwvs_pkg::*;

  localparam logic [5:0] CFG_BYTES = 6'(CFG_WORDS * 4);

  // Unknown codes fall through as neither known nor transport specific
  always_comb begin
    known     = 1'b1;
    transport = 1'b1;
    exp_len   = 6'h00;
    unique case (op)
      OP_NOOP:         transport = 1'b0;
      OP_SET_REV:      exp_len = LEN_REV;
      OP_READ_VQ_CONF: exp_len = LEN_VQ_CONF;
      OP_SET_VQ:       exp_len = rev1 ? LEN_SET_VQ : LEN_SET_VQ0;
      OP_WRITE_STATUS: exp_len = LEN_STATUS;
      OP_READ_FEAT,
      OP_WRITE_FEAT:   exp_len = LEN_FEAT;
      OP_READ_CONF,
      OP_WRITE_CONF:   exp_len = CFG_BYTES;
      OP_SET_IND,
      OP_SET_CONF_IND: exp_len = LEN_IND;
      OP_SET_IND_ADPT: exp_len = LEN_ADAPTER;
      OP_VDEV_RESET:   exp_len = 6'h00;
      default: begin
        known     = 1'b0;
        transport = 1'b0;
      end
    endcase
  end

endmodule

// File: test/ccwvs_properties.sv
`timescale 1ns/1ps
// Bus-level checks on the setup interpreter ports
module ccwvs_properties
  import ccwvs_pkg::*;
#(
  parameter int CFG_WORDS = 4
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup phase; the answer is due in the access cycle that follows
  sequence setup_s;
    psel && !penable;
  endsequence
  answer_next_a: assert property (setup_s |=> pready) else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held past access");
  error_qual_a: assert property (pslverr |-> pready) else $error("error without ready");
  idle_quiet_a: assert property (!psel |-> !pready) else $error("answer while idle");
  gap_error_a: assert property (setup_s ##0 (paddr > OFS_FEAT_DRV && paddr < 8'h40) |=> pslverr)
    else $error("gap address not refused");
  cfg_edge_a: assert property (setup_s ##0 (paddr[7:5] == REGION_CONFIG && paddr[4:2] >= CFG_WORDS) |=> pslverr)
    else $error("config word beyond space not refused");
  cmd_ok_a: assert property (setup_s ##0 paddr == OFS_CMD |=> !pslverr)
    else $error("command write refused on bus");
  stat_byte_a: assert property (setup_s ##0 (!pwrite && paddr == OFS_STATUS) |=> prdata[31:8] == 24'h00_0000)
    else $error("status wider than a byte");
endmodule

bind ccwvs_setup ccwvs_properties #(.CFG_WORDS(CFG_WORDS)) i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata));

// File: test/ccwvs_drv.sv
`timescale 1ns/1ps
// Guest-side requester: one register-bus transfer at a time
module ccwvs_drv (
  // Clock
  input  wire logic        pclk,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // Answer
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             tmo
);
  // Idle bus from time zero
  initial begin
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0000_0000;
    tmo     <= 1'b0;
  end
  // Request held until ready is sampled high at a rising edge; read data taken at that same edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    q = prdata;
    tmo     <= (n >= 64);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so no signal is driven twice in one step
    @(posedge pclk);
  endtask
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
// Setup command sequences run over the register bus
module testbench;
  import ccwvs_pkg::*;
  localparam logic [15:0] QMAX = 16'h0100;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, tmo;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          error_cnt = 0;
  int          num_checks = 0;
  // Bus clock
  always #5 pclk = ~pclk;
  // Device and requester
  ccwvs_setup #(.QUEUE_MAX_NUM(QMAX)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
  ccwvs_drv i_drv (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .tmo(tmo));
  // Verdict
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One transfer; a hung bus counts as a mismatch and ends the run
  task automatic x(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_drv.xfer(w, a, d, q);
    if (tmo) begin
      chk(32'h0000_0000, 32'h0000_0001);
      stop_test();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    x(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  // Length, then opcode; the done and reject flags are judged, q keeps the result word
  task automatic cmd(input logic [7:0] op, input logic [5:0] len, input logic rej);
    x(1'b1, OFS_LEN, 32'(len));
    x(1'b1, OFS_CMD, 32'(op));
    x(1'b0, OFS_RESULT, 32'h0000_0000);
    chk(32'(q[RES_DONE]), 32'h0000_0001);
    chk(32'(q[RES_REJECT]), 32'(rej));
  endtask
  // Payload words base, base+1, ...
  task automatic fill(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++) x(1'b1, 8'(8'h40 + 4 * i), b + 32'(i));
  endtask
  task automatic info(input logic [11:0] s, input logic [31:0] e);
    x(1'b1, OFS_INFO_SEL, 32'(s));
    rchk(OFS_INFO, e);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(OFS_CTRL, 32'h0000_0001);
    rchk(OFS_STAT_OK, 32'h0000_00ff);
    // Non-transitional: early command refused, revisions 2, 0, then 1 tried
    x(1'b1, OFS_CTRL, 32'h0000_0002);
    fill(32'h0000_0000, 2);
    cmd(OP_READ_FEAT, LEN_FEAT, 1'b1);
    fill(32'h0002_0000, 1);
    cmd(OP_SET_REV, LEN_REV, 1'b1);
    fill(32'h0000_0000, 1);
    cmd(OP_SET_REV, LEN_REV, 1'b1);
    fill(32'h0001_0000, 1);
    cmd(OP_SET_REV, LEN_REV, 1'b0);
    chk(32'(q[3:2]), 32'h0000_0003);
    cmd(8'h55, LEN_REV, 1'b1);
    cmd(OP_NOOP, LEN_REV, 1'b0);
    // Queue query, then placement of queue 2 with 64 buffers
    fill(32'h0001_0000, 1);
    cmd(OP_READ_VQ_CONF, LEN_VQ_CONF, 1'b0);
    rchk(8'h40, 32'h0001_0000 | 32'(QMAX));
    fill(32'h0002_003d, 8);
    cmd(OP_SET_VQ, LEN_SET_VQ, 1'b0);
    info({4'h2, 3'h0, INF_DESC_LO}, 32'h0002_003e);
    info({4'h2, 3'h0, INF_USED_LO}, 32'h0002_0044);
    info({4'h2, 3'h0, INF_NUM}, 32'h0000_0040);
    x(1'b1, 8'h4c, 32'h0002_0101);
    cmd(OP_SET_VQ, LEN_SET_VQ, 1'b1);
    // Status adopted, then an unacceptable one leaves it alone
    x(1'b1, OFS_STAT_OK, 32'h0000_000f);
    fill(32'h0700_0000, 1);
    cmd(OP_WRITE_STATUS, LEN_STATUS, 1'b0);
    rchk(OFS_STATUS, 32'h0000_0007);
    fill(32'h8100_0000, 1);
    cmd(OP_WRITE_STATUS, LEN_STATUS, 1'b1);
    rchk(OFS_STATUS, 32'h0000_0007);
    // Feature words cross in byte-reversed order
    x(1'b1, OFS_FEAT_DEV, 32'h1234_5678);
    fill(32'h0000_0000, 2);
    cmd(OP_READ_FEAT, LEN_FEAT, 1'b0);
    rchk(8'h40, 32'h7856_3412);
    x(1'b1, 8'h40, 32'h4433_2211);
    cmd(OP_WRITE_FEAT, LEN_FEAT, 1'b0);
    rchk(OFS_FEAT_DRV, 32'h1122_3344);
    cmd(OP_WRITE_FEAT, 6'h04, 1'b1);
    // Whole configuration space only
    fill(32'hc0f0_0000, 4);
    cmd(OP_WRITE_CONF, 6'h10, 1'b0);
    for (int i = 0; i < 4; i++) rchk(8'(8'h60 + 4 * i), 32'hc0f0_0000 + 32'(i));
    cmd(OP_READ_CONF, 6'h0c, 1'b1);
    x(1'b0, 8'h70, 32'h0000_0000);
    x(1'b0, 8'h30, 32'h0000_0000);
    // Classic indicators lock out adapter ones until a device reset
    fill(32'h2000_0000, 2);
    cmd(OP_SET_IND, LEN_IND, 1'b0);
    info(12'(INF_IND_LO), 32'h2000_0001);
    cmd(OP_SET_CONF_IND, LEN_IND, 1'b0);
    chk(32'(q[RES_CONF_IND]), 32'h0000_0001);
    cmd(OP_SET_IND_ADPT, LEN_ADAPTER, 1'b1);
    cmd(OP_VDEV_RESET, 6'h00, 1'b0);
    fill(32'ha000_0000, 7);
    cmd(OP_SET_IND_ADPT, LEN_ADAPTER, 1'b0);
    info(12'(INF_BIT_LO), 32'ha000_0005);
    info(12'(INF_ISC), 32'h0000_00a0);
    cmd(OP_SET_IND, LEN_IND, 1'b1);
    // Transitional: re-enable unsets revision, early command fixes revision 0
    x(1'b1, OFS_CTRL, 32'h0000_0001);
    x(1'b1, OFS_CTRL, 32'h0000_0003);
    cmd(OP_NOOP, LEN_REV, 1'b0);
    chk(32'(q[3:2]), 32'h0000_0000);
    cmd(OP_READ_FEAT, LEN_FEAT, 1'b0);
    chk(32'(q[3:2]), 32'h0000_0001);
    fill(32'h0001_0000, 1);
    cmd(OP_SET_REV, LEN_REV, 1'b1);
    fill(32'h0001_001d, 4);
    cmd(OP_SET_VQ, LEN_SET_VQ0, 1'b0);
    info({4'h1, 3'h0, INF_ALIGN}, 32'h0001_001f);
    stop_test();
  end
endmodule
